// ---- hdl/data_addr_gen.sv ----
/*
 * Data address generation: page registers and translation, effective address
 * forming, dual prefetch pointers, software stack and data memory arbitration.
 * Assumes all inputs synchronous to ref_clk_i and a one-cycle register master.
 */
// Chosen here: the address map and the address-and-strobe port.
// Notes on behaviour
// R01: low base region always reachable as page zero
// R02: both page registers reset to one
// R03: upper half with page zero traps
// R04: writing zero to a page register ignored
// R05: other pages only through upper half
// R06: page n maps linearly at (n mod 512) times 32K
// R07: arbiter grants only the highest requester
// R08: default order cpu, dma, debug
// R09: priority setting takes only two values
// R10: stack pointer bit zero always zero
// R11: stack pointer resets to 0x1000
// R12: push writes then increments, pop decrements first
// R13: pc low word first, upper word zero-extended
// R14: exception packs status low byte with pc
// R15: stack and active frame pointer never paged
// R16: file register address from 13-bit field
// R17: indirect, pre/post modify, indexed, literal offset
// R18: first operand register, second register/memory/literal
// R19: one shared offset register field per move
// R20: indexed mode and 8/16-bit literals for moves
// R21: first pointer pair x, second pair y
// R22: prefetch modes; indexed only on second pointer
// R23: read address from nine page bits, 15 ea bits
// R24: read page ten bits, write page nine bits
// R25: arbitration re-evaluated every cycle
module data_addr_gen
    import agu_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [15:0] reg_rdata_o,
    // effective address generation
    input wire agu_req_t agu_req_i,
    output agu_rsp_t agu_rsp_o,
    // dual prefetch
    input wire dsp_req_t dsp_req_i,
    output dsp_rsp_t dsp_rsp_o,
    // software stack
    input wire stk_req_t stk_req_i,
    output stk_mem_t stk_mem_o,
    output logic stk_busy_o,
    output logic [15:0] sp_o,
    // data memory arbitration
    input wire logic [2:0] mem_req_i,
    output logic [2:0] mem_gnt_o
);
    typedef enum logic {PH_IDLE, PH_PC_HI} stk_phase_t;
    typedef struct packed {
        logic [9:0] rpage; // R24
        logic [8:0] wpage;
        logic [15:0] prio;
        logic [15:0] sp;
        stk_phase_t phase;
        logic [15:0] hi_word;
        logic [15:0] rdata;
        agu_rsp_t agu;
        dsp_rsp_t dsp;
        stk_mem_t mem;
        logic busy;
        logic [2:0] gnt;
    } state_t;

    state_t q;
    state_t d;

    always_comb begin
        logic [15:0] ea;
        logic [9:0] page;
        logic [15:0] ptr;
        logic [15:0] step;
        ea = 16'h0000;
        page = 10'h000;
        ptr = 16'h0000;
        step = 16'h0000;
        d = q;

        // stack: the upper pc word goes out in the cycle after the low word
        d.mem = '0;
        d.busy = 1'b0;
        unique case (q.phase)
            PH_IDLE: begin
                unique case (stk_req_i.cmd)
                    STK_NONE: begin
                    end
                    STK_PUSH: begin
                        d.mem.we = 1'b1; // R12
                        d.mem.addr = q.sp;
                        d.mem.wdata = stk_req_i.data;
                        d.sp = q.sp + STK_STEP;
                    end
                    STK_POP: begin
                        d.mem.re = 1'b1; // R12
                        d.mem.addr = q.sp - STK_STEP;
                        d.sp = q.sp - STK_STEP;
                    end
                    STK_CALL, STK_EXC: begin
                        d.mem.we = 1'b1; // R13
                        d.mem.addr = q.sp;
                        d.mem.wdata = stk_req_i.pc[15:0];
                        d.sp = q.sp + STK_STEP;
                        d.phase = PH_PC_HI;
                        d.busy = 1'b1;
                        if (stk_req_i.cmd == STK_EXC) begin
                            d.hi_word = {stk_req_i.status_low, 1'b0, stk_req_i.pc[22:16]}; // R14
                        end else begin
                            d.hi_word = {9'h000, stk_req_i.pc[22:16]}; // R13
                        end
                    end
                endcase
            end
            PH_PC_HI: begin
                d.mem.we = 1'b1; // R13
                d.mem.addr = q.sp;
                d.mem.wdata = q.hi_word;
                d.sp = q.sp + STK_STEP;
                d.phase = PH_IDLE;
            end
        endcase

        // register port; a software stack pointer write wins over a stack move
        d.rdata = 16'h0000;
        if (reg_re_i) begin
            if (reg_addr_i == OFS_RPAGE) begin
                d.rdata = {6'h00, q.rpage};
            end else if (reg_addr_i == OFS_WPAGE) begin
                d.rdata = {7'h00, q.wpage};
            end else if (reg_addr_i == OFS_PRIO) begin
                d.rdata = q.prio;
            end else if (reg_addr_i == OFS_SP) begin
                d.rdata = q.sp;
            end
        end
        if (reg_we_i) begin
            if (reg_addr_i == OFS_RPAGE && reg_wdata_i[9:0] != 10'h000) begin
                d.rpage = reg_wdata_i[9:0]; // R04
            end
            if (reg_addr_i == OFS_WPAGE && reg_wdata_i[8:0] != 9'h000) begin
                d.wpage = reg_wdata_i[8:0]; // R04
            end
            // reserved settings are dropped so the order stays defined
            if (reg_addr_i == OFS_PRIO && (reg_wdata_i == PRIO_DEFAULT || reg_wdata_i == PRIO_DMA_UP)) begin
                d.prio = reg_wdata_i; // R09
            end
            if (reg_addr_i == OFS_SP) begin
                d.sp = {reg_wdata_i[15:1], 1'b0}; // R10
            end
        end

        // effective address; offset_reg is the one field shared by source and destination
        d.agu = '0;
        d.agu.valid = agu_req_i.valid;
        d.agu.access = 1'b1;
        unique case (agu_req_i.mode)
            EA_REG_DIRECT: begin
                d.agu.access = 1'b0; // R18
                d.agu.operand = agu_req_i.ptr;
            end
            EA_FILE: ea = {3'b000, agu_req_i.literal[FILE_ADDR_W-1:0]}; // R16
            EA_INDIRECT: ea = agu_req_i.ptr; // R17
            EA_POST_MOD: begin
                ea = agu_req_i.ptr; // R17
                d.agu.upd = 1'b1;
                d.agu.ptr_new = agu_req_i.ptr + agu_req_i.modifier;
            end
            EA_PRE_MOD: begin
                ea = agu_req_i.ptr + agu_req_i.modifier; // R17
                d.agu.upd = 1'b1;
                d.agu.ptr_new = ea;
            end
            EA_INDEXED: ea = agu_req_i.ptr + agu_req_i.offset_reg; // R19 R20
            EA_LIT_OFFSET: ea = agu_req_i.ptr + agu_req_i.literal; // R17
            EA_LIT5: begin
                d.agu.access = 1'b0; // R18
                d.agu.operand = {11'h000, agu_req_i.literal[4:0]};
            end
            EA_LIT8: begin
                d.agu.access = 1'b0; // R20
                d.agu.operand = {8'h00, agu_req_i.literal[7:0]};
            end
            EA_LIT16: begin
                d.agu.access = 1'b0; // R20
                d.agu.operand = agu_req_i.literal;
            end
            default: d.agu.access = 1'b0;
        endcase
        d.agu.base_ea = ea;
        page = agu_req_i.is_write ? {1'b0, q.wpage} : q.rpage;
        if (agu_req_i.src == SRC_STACK || (agu_req_i.src == SRC_FRAME && agu_req_i.frame_active)) begin
            d.agu.ext_addr = {8'h00, ea}; // R15
        end else if (!ea[15]) begin
            d.agu.ext_addr = {8'h00, ea}; // R01
        end else if (page == 10'h000) begin
            d.agu.trap = d.agu.access; // R03
        end else begin
            d.agu.paged = d.agu.access; // R05
            d.agu.ext_addr = {page[8:0], ea[14:0]}; // R06 R23
        end
        if (!agu_req_i.valid) begin
            d.agu = '0;
        end

        // dual prefetch: space 0 is x, space 1 is y
        d.dsp = '0;
        d.dsp.valid = dsp_req_i.valid;
        for (int s = 0; s < 2; s++) begin
            ptr = dsp_req_i.ptrs[2*s + int'(dsp_req_i.sel_b[s])]; // R21
            step = 16'h0000;
            d.dsp.addr[s] = ptr;
            unique case (dsp_req_i.mode[s])
                DSP_INDIRECT: step = 16'h0000; // R22
                DSP_POST2: step = 16'h0002;
                DSP_POST4: step = 16'h0004;
                DSP_POST6: step = 16'h0006;
                DSP_INDEXED: begin
                    d.dsp.addr[s] = ptr + dsp_req_i.offs[s]; // R22
                    d.dsp.illegal[s] = !dsp_req_i.sel_b[s];
                end
                default: d.dsp.illegal[s] = 1'b1;
            endcase
            d.dsp.ptr_new[s] = ptr + step;
        end
        if (!dsp_req_i.valid) begin
            d.dsp = '0;
        end

        // arbitration, decided afresh each cycle; losers just ask again
        d.gnt = 3'b000; // R25
        if (q.prio == PRIO_DMA_UP) begin
            if (mem_req_i[M_DMA]) d.gnt[M_DMA] = 1'b1; // R09
            else if (mem_req_i[M_CPU]) d.gnt[M_CPU] = 1'b1;
            else if (mem_req_i[M_DBG]) d.gnt[M_DBG] = 1'b1;
        end else begin
            if (mem_req_i[M_CPU]) d.gnt[M_CPU] = 1'b1; // R07 R08
            else if (mem_req_i[M_DMA]) d.gnt[M_DMA] = 1'b1;
            else if (mem_req_i[M_DBG]) d.gnt[M_DBG] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.rpage <= RPAGE_RST; // R02
            q.wpage <= WPAGE_RST;
            q.sp <= SP_RST; // R11
            q.prio <= PRIO_DEFAULT;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign reg_rdata_o = q.rdata;
    assign agu_rsp_o = q.agu;
    assign dsp_rsp_o = q.dsp;
    assign stk_mem_o = q.mem;
    assign stk_busy_o = q.busy;
    assign sp_o = q.sp;
    assign mem_gnt_o = q.gnt;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    property p_low_region;
        agu_rsp_o.valid && agu_rsp_o.access && agu_rsp_o.base_ea <= LOW_REGION_TOP
            |-> agu_rsp_o.ext_addr == {8'h00, agu_rsp_o.base_ea} && !agu_rsp_o.trap;
    endproperty
    a_low_region: assert property (p_low_region) else $error("low region not reached as page zero"); // R01
    property p_reset_vals;
        $fell(rst_i) |-> q.rpage == RPAGE_RST && q.wpage == WPAGE_RST && sp_o == SP_RST;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong"); // R02 R11
    property p_trap_cause;
        agu_rsp_o.trap |-> agu_rsp_o.base_ea[15] && agu_rsp_o.access && !agu_rsp_o.paged;
    endproperty
    a_trap_cause: assert property (p_trap_cause) else $error("trap without upper half access"); // R03
    property p_zero_write;
        ce_i && reg_we_i && reg_addr_i == OFS_RPAGE && reg_wdata_i[9:0] == 10'h000 |=> $stable(q.rpage);
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero write changed read page"); // R04
    property p_paged_map;
        agu_rsp_o.paged |-> agu_rsp_o.base_ea[15] && agu_rsp_o.ext_addr[14:0] == agu_rsp_o.base_ea[14:0]
            && agu_rsp_o.ext_addr[23:15] != 9'h000;
    endproperty
    a_paged_map: assert property (p_paged_map) else $error("paged address wrongly formed"); // R05 R06
    property p_arb_single;
        ce_i && mem_req_i != 3'b000 |=> $onehot(mem_gnt_o) && (mem_gnt_o & $past(mem_req_i)) == mem_gnt_o;
    endproperty
    a_arb_single: assert property (p_arb_single) else $error("grant not single or not requested"); // R07
    property p_arb_default;
        ce_i && q.prio == PRIO_DEFAULT && mem_req_i[M_CPU] |=> mem_gnt_o[M_CPU];
    endproperty
    a_arb_default: assert property (p_arb_default) else $error("cpu not first by default"); // R08
    property p_arb_raised;
        ce_i && q.prio == PRIO_DMA_UP && mem_req_i[M_DMA] |=> mem_gnt_o[M_DMA];
    endproperty
    a_arb_raised: assert property (p_arb_raised) else $error("dma not first when raised"); // R09
    property p_sp_align;
        !sp_o[0];
    endproperty
    a_sp_align: assert property (p_sp_align) else $error("stack pointer misaligned"); // R10
    property p_push;
        ce_i && !stk_busy_o && stk_req_i.cmd == STK_PUSH && !reg_we_i
            |=> stk_mem_o.we && stk_mem_o.addr == $past(sp_o) && sp_o == $past(sp_o) + STK_STEP;
    endproperty
    a_push: assert property (p_push) else $error("push order wrong"); // R12
    property p_call_hi;
        ce_i && !stk_busy_o && stk_req_i.cmd == STK_CALL ##1 ce_i |=> stk_mem_o.we && stk_mem_o.wdata[15:7] == 9'h000;
    endproperty
    a_call_hi: assert property (p_call_hi) else $error("call upper word not zero-extended"); // R13
    property p_exc_hi;
        ce_i && !stk_busy_o && stk_req_i.cmd == STK_EXC ##1 ce_i
            |=> stk_mem_o.we && stk_mem_o.wdata[15:8] == $past(stk_req_i.status_low, 2);
    endproperty
    a_exc_hi: assert property (p_exc_hi) else $error("status byte not stacked"); // R14
    property p_stack_flat;
        ce_i && agu_req_i.valid && agu_req_i.src == SRC_STACK |=> !agu_rsp_o.paged && !agu_rsp_o.trap;
    endproperty
    a_stack_flat: assert property (p_stack_flat) else $error("stack access paged"); // R15
    property p_file;
        ce_i && agu_req_i.valid && agu_req_i.mode == EA_FILE |=> agu_rsp_o.base_ea[15:13] == 3'b000;
    endproperty
    a_file: assert property (p_file) else $error("file address beyond near space"); // R16
    property p_dsp_index;
        ce_i && dsp_req_i.valid && dsp_req_i.mode[0] == DSP_INDEXED && !dsp_req_i.sel_b[0] |=> dsp_rsp_o.illegal[0];
    endproperty
    a_dsp_index: assert property (p_dsp_index) else $error("indexed on first x pointer not flagged"); // R22

    c_exc: cover property (ce_i && stk_req_i.cmd == STK_EXC && !stk_busy_o);
    c_dma_wins: cover property (q.prio == PRIO_DMA_UP && mem_req_i == 3'b011 && ce_i);
    c_paged: cover property (agu_rsp_o.paged);
endmodule

// ---- hdl/agu_pkg.sv ----
/*
 * Shared constants and carriers for the data address generation block.
 * Assumes one core clock and a synchronous reset in the user of this package.
 */
package agu_pkg;
    localparam int EXT_W = 24;
    localparam int FILE_ADDR_W = 13;
    // register port offsets
    localparam logic [7:0] OFS_RPAGE = 8'h00;
    localparam logic [7:0] OFS_WPAGE = 8'h04;
    localparam logic [7:0] OFS_PRIO = 8'h08;
    localparam logic [7:0] OFS_SP = 8'h0C;
    // reset values and fixed figures
    localparam logic [9:0] RPAGE_RST = 10'h001;
    localparam logic [8:0] WPAGE_RST = 9'h001;
    localparam logic [15:0] SP_RST = 16'h1000;
    localparam logic [15:0] PRIO_DEFAULT = 16'h0000;
    localparam logic [15:0] PRIO_DMA_UP = 16'h0020;
    localparam logic [15:0] LOW_REGION_TOP = 16'h2FFF;
    localparam logic [15:0] STK_STEP = 16'h0002;
    // bus master indices in request and grant vectors
    localparam int M_CPU = 0;
    localparam int M_DMA = 1;
    localparam int M_DBG = 2;

    typedef enum logic [3:0] {
        EA_REG_DIRECT, EA_FILE, EA_INDIRECT, EA_POST_MOD, EA_PRE_MOD,
        EA_INDEXED, EA_LIT_OFFSET, EA_LIT5, EA_LIT8, EA_LIT16
    } ea_mode_t;
    typedef enum logic [1:0] {SRC_GENERAL, SRC_STACK, SRC_FRAME} addr_src_t;
    typedef enum logic [2:0] {DSP_INDIRECT, DSP_POST2, DSP_POST4, DSP_POST6, DSP_INDEXED} dsp_mode_t;
    typedef enum logic [2:0] {STK_NONE, STK_PUSH, STK_POP, STK_CALL, STK_EXC} stack_cmd_t;

    typedef struct packed {
        logic valid;
        logic is_write;
        ea_mode_t mode;
        addr_src_t src;
        logic frame_active;
        logic [15:0] ptr;
        logic [15:0] offset_reg;
        logic [15:0] modifier;
        logic [15:0] literal;
    } agu_req_t;
    typedef struct packed {
        logic valid;
        logic access;
        logic paged;
        logic trap;
        logic [15:0] base_ea;
        logic [EXT_W-1:0] ext_addr;
        logic [15:0] operand;
        logic upd;
        logic [15:0] ptr_new;
    } agu_rsp_t;
    typedef struct packed {
        logic valid;
        logic [3:0][15:0] ptrs;
        logic [1:0][15:0] offs;
        dsp_mode_t [1:0] mode;
        logic [1:0] sel_b;
    } dsp_req_t;
    typedef struct packed {
        logic valid;
        logic [1:0] illegal;
        logic [1:0][15:0] addr;
        logic [1:0][15:0] ptr_new;
    } dsp_rsp_t;
    typedef struct packed {
        stack_cmd_t cmd;
        logic [15:0] data;
        logic [22:0] pc;
        logic [7:0] status_low;
    } stk_req_t;
    typedef struct packed {
        logic we;
        logic re;
        logic [15:0] addr;
        logic [15:0] wdata;
    } stk_mem_t;
endpackage

// ---- tb/mem_masters.sv ----
/*
 * Behavioural model of the cpu, dma and debug masters asking for data memory.
 * Assumes the arbiter answers with a registered one-hot grant on the same clock.
 */
module mem_masters (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // stimulus and arbiter side
    input wire logic [2:0] start_i,
    input wire logic [2:0] gnt_i,
    output logic [2:0] req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] pend_q;
    // a suspended master keeps asking until its grant shows
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pend_q <= 3'h0;
        end else begin
            pend_q <= (pend_q | start_i) & ~gnt_i;
        end
    end
    // the grant cycle is the served access, so the request drops at once
    assign req_o = pend_q & ~gnt_i;
endmodule

// ---- tb/test_data_addr_gen.sv ----
/*
 * Self-checking bench for data_addr_gen: registers, translation, prefetch, stack, arbitration.
 * Assumes the design of hdl/ and the master model mem_masters on the memory request side.
 */
module test_data_addr_gen import agu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic reg_we_i = 1'b0;
    logic reg_re_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic [15:0] reg_rdata_o;
    agu_req_t agu_req_i = '0;
    agu_rsp_t agu_rsp_o;
    dsp_req_t dsp_req_i = '0;
    dsp_rsp_t dsp_rsp_o;
    stk_req_t stk_req_i = '0;
    stk_mem_t stk_mem_o;
    logic stk_busy_o;
    logic [15:0] sp_o;
    logic [2:0] go = 3'h0;
    logic [2:0] mem_req_i;
    logic [2:0] mem_gnt_o;
    dsp_req_t dq;
    int mismatches = 0;
    int cmp_count = 0;

    always #20 ref_clk_i = ~ref_clk_i;

    data_addr_gen data_addr_gen_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
        .reg_rdata_o(reg_rdata_o), .agu_req_i(agu_req_i), .agu_rsp_o(agu_rsp_o), .dsp_req_i(dsp_req_i),
        .dsp_rsp_o(dsp_rsp_o), .stk_req_i(stk_req_i), .stk_mem_o(stk_mem_o), .stk_busy_o(stk_busy_o),
        .sp_o(sp_o), .mem_req_i(mem_req_i), .mem_gnt_o(mem_gnt_o));
    mem_masters mem_masters_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .start_i(go), .gnt_i(mem_gnt_o),
        .req_o(mem_req_i));

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_we_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_we_i <= 1'b0;
    endtask
    task rd(input string n, input logic [7:0] a, input logic [15:0] e);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_re_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_re_i <= 1'b0;
        #1 chk(n, e, reg_rdata_o);
    endtask
    function automatic agu_req_t mk(input ea_mode_t m, input addr_src_t s, input logic fa, input logic w,
        input logic [15:0] p, input logic [15:0] x);
        return '{1'b1, w, m, s, fa, p, x, x, x};
    endfunction
    task agu(input agu_req_t r, input logic [15:0] eb, input logic [23:0] ex, input logic pg,
        input logic [15:0] pn);
        @(posedge ref_clk_i);
        agu_req_i <= r;
        @(posedge ref_clk_i);
        agu_req_i <= '0;
        #1 chk("agu base", eb, agu_rsp_o.base_ea);
        chk("agu ext", ex, agu_rsp_o.ext_addr);
        chk("agu paged", pg, agu_rsp_o.paged);
        if (r.mode == EA_POST_MOD || r.mode == EA_PRE_MOD) chk("agu ptr_new", pn, agu_rsp_o.ptr_new);
    endtask
    task dsp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] nx, input logic [15:0] ny,
        input logic [1:0] il);
        @(posedge ref_clk_i);
        dsp_req_i <= dq;
        @(posedge ref_clk_i);
        dsp_req_i <= '0;
        #1 chk("dsp illegal", il, dsp_rsp_o.illegal);
        if (il == 2'h0) begin
            chk("dsp x", x, dsp_rsp_o.addr[0]);
            chk("dsp y", y, dsp_rsp_o.addr[1]);
            chk("dsp x new", nx, dsp_rsp_o.ptr_new[0]);
            chk("dsp y new", ny, dsp_rsp_o.ptr_new[1]);
        end
    endtask
    task stk_word(input logic [1:0] s, input logic [15:0] a, input logic [15:0] d);
        chk("stack strobes", s, {stk_mem_o.we, stk_mem_o.re});
        chk("stack addr", a, stk_mem_o.addr);
        if (s[1]) chk("stack data", d, stk_mem_o.wdata);
    endtask
    task stk(input stack_cmd_t c, input logic [15:0] d, input logic [22:0] pc, input logic [7:0] sl,
        input logic [1:0] s, input logic [15:0] a, input logic [15:0] ed);
        @(posedge ref_clk_i);
        stk_req_i <= '{c, d, pc, sl};
        @(posedge ref_clk_i);
        stk_req_i <= '0;
        #1 stk_word(s, a, ed);
    endtask
    task arb(input logic [2:0] v, input logic [2:0] g1, input logic [2:0] g2, input logic [2:0] g3);
        @(posedge ref_clk_i);
        go <= v;
        @(posedge ref_clk_i);
        go <= 3'h0;
        @(posedge ref_clk_i);
        #1 chk("grant 1", g1, mem_gnt_o);
        @(posedge ref_clk_i);
        #1 chk("grant 2", g2, mem_gnt_o);
        @(posedge ref_clk_i);
        #1 chk("grant 3", g3, mem_gnt_o);
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #(40 * 4000);
        mismatches++;
        $display("[ERR] watchdog expected done seen timeout");
        finish_test;
    end

    initial begin
        repeat (16) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        #1 chk("sp out", 16'h1000, sp_o);
        rd("read page", OFS_RPAGE, 16'h0001);
        rd("write page", OFS_WPAGE, 16'h0001);
        rd("priority", OFS_PRIO, 16'h0000);
        rd("unmapped", 8'h10, 16'h0000);
        wr(OFS_RPAGE, 16'h0000);
        rd("read page", OFS_RPAGE, 16'h0001);
        wr(OFS_RPAGE, 16'hFFFF);
        wr(OFS_WPAGE, 16'hFFFF);
        rd("read page", OFS_RPAGE, 16'h03FF);
        rd("write page", OFS_WPAGE, 16'h01FF);
        wr(OFS_RPAGE, 16'h0002);
        wr(OFS_WPAGE, 16'h0005);
        $display("test registers done");
        agu(mk(EA_INDIRECT, SRC_GENERAL, 1'b0, 1'b0, 16'h8010, 16'h0000), 16'h8010, 24'h010010, 1'b1, 0);
        agu(mk(EA_INDIRECT, SRC_GENERAL, 1'b0, 1'b1, 16'h8000, 16'h0000), 16'h8000, 24'h028000, 1'b1, 0);
        agu(mk(EA_INDIRECT, SRC_GENERAL, 1'b0, 1'b0, 16'h2FFF, 16'h0000), 16'h2FFF, 24'h002FFF, 1'b0, 0);
        agu(mk(EA_INDIRECT, SRC_STACK, 1'b0, 1'b0, 16'h9000, 16'h0000), 16'h9000, 24'h009000, 1'b0, 0);
        agu(mk(EA_INDIRECT, SRC_FRAME, 1'b1, 1'b1, 16'hA000, 16'h0000), 16'hA000, 24'h00A000, 1'b0, 0);
        agu(mk(EA_INDIRECT, SRC_FRAME, 1'b0, 1'b0, 16'hA000, 16'h0000), 16'hA000, 24'h012000, 1'b1, 0);
        agu(mk(EA_POST_MOD, SRC_GENERAL, 1'b0, 1'b0, 16'h1010, 16'h0004), 16'h1010, 24'h001010, 1'b0,
            16'h1014);
        agu(mk(EA_PRE_MOD, SRC_GENERAL, 1'b0, 1'b0, 16'h1010, 16'h0004), 16'h1014, 24'h001014, 1'b0,
            16'h1014);
        agu(mk(EA_INDEXED, SRC_GENERAL, 1'b0, 1'b0, 16'h1000, 16'h0020), 16'h1020, 24'h001020, 1'b0, 0);
        agu(mk(EA_LIT_OFFSET, SRC_GENERAL, 1'b0, 1'b0, 16'h1000, 16'h0006), 16'h1006, 24'h001006, 1'b0, 0);
        agu(mk(EA_FILE, SRC_GENERAL, 1'b0, 1'b0, 16'h0000, 16'hFFFF), 16'h1FFF, 24'h001FFF, 1'b0, 0);
        chk("agu access", 1'b1, agu_rsp_o.access);
        agu(mk(EA_LIT5, SRC_GENERAL, 1'b0, 1'b0, 16'h1234, 16'hFFFF), 16'h0000, 24'h000000, 1'b0, 0);
        chk("agu operand", 16'h001F, agu_rsp_o.operand);
        chk("agu access", 1'b0, agu_rsp_o.access);
        agu(mk(EA_LIT8, SRC_GENERAL, 1'b0, 1'b0, 16'h1234, 16'hFFFF), 16'h0000, 24'h000000, 1'b0, 0);
        chk("agu operand", 16'h00FF, agu_rsp_o.operand);
        agu(mk(EA_LIT16, SRC_GENERAL, 1'b0, 1'b0, 16'h1234, 16'hABCD), 16'h0000, 24'h000000, 1'b0, 0);
        chk("agu operand", 16'hABCD, agu_rsp_o.operand);
        agu(mk(EA_REG_DIRECT, SRC_GENERAL, 1'b0, 1'b0, 16'h1234, 16'h0000), 16'h0000, 24'h000000, 1'b0, 0);
        chk("agu operand", 16'h1234, agu_rsp_o.operand);
        $display("test translation done");
        dq = '0;
        dq.valid = 1'b1;
        dq.ptrs = {16'h0400, 16'h0200, 16'h0300, 16'h0100};
        dq.offs = {16'h0010, 16'h0008};
        dq.mode[0] = DSP_POST2;
        dq.mode[1] = DSP_POST6;
        dsp(16'h0100, 16'h0200, 16'h0102, 16'h0206, 2'h0);
        dq.mode[0] = DSP_POST4;
        dq.mode[1] = DSP_INDEXED;
        dq.sel_b = 2'h3;
        dsp(16'h0300, 16'h0410, 16'h0304, 16'h0400, 2'h0);
        dq.mode[0] = DSP_INDEXED;
        dq.mode[1] = DSP_INDIRECT;
        dq.sel_b = 2'h0;
        dsp(16'h0000, 16'h0200, 16'h0000, 16'h0200, 2'h1);
        $display("test prefetch done");
        stk(STK_PUSH, 16'hAAAA, 23'h000000, 8'h00, 2'h2, 16'h1000, 16'hAAAA);
        chk("sp out", 16'h1002, sp_o);
        stk(STK_POP, 16'h0000, 23'h000000, 8'h00, 2'h1, 16'h1000, 16'h0000);
        stk(STK_CALL, 16'h0000, 23'h7A1234, 8'hC5, 2'h2, 16'h1000, 16'h1234);
        chk("stack busy", 1'b1, stk_busy_o);
        @(posedge ref_clk_i);
        #1 stk_word(2'h2, 16'h1002, 16'h007A);
        stk(STK_EXC, 16'h0000, 23'h551234, 8'hC5, 2'h2, 16'h1004, 16'h1234);
        @(posedge ref_clk_i);
        #1 stk_word(2'h2, 16'h1006, 16'hC555);
        chk("sp out", 16'h1008, sp_o);
        wr(OFS_SP, 16'h2001);
        rd("sp reg", OFS_SP, 16'h2000);
        // a write while the enable is low must not land
        @(posedge ref_clk_i);
        ce_i <= 1'b0;
        wr(OFS_SP, 16'h3000);
        ce_i <= 1'b1;
        rd("sp frozen", OFS_SP, 16'h2000);
        $display("test stack done");
        arb(3'h7, 3'h1, 3'h2, 3'h4);
        wr(OFS_PRIO, 16'h0020);
        arb(3'h7, 3'h2, 3'h1, 3'h4);
        wr(OFS_PRIO, 16'h0010);
        rd("priority", OFS_PRIO, 16'h0020);
        arb(3'h5, 3'h1, 3'h4, 3'h0);
        wr(OFS_PRIO, 16'h0000);
        arb(3'h3, 3'h1, 3'h2, 3'h0);
        $display("test arbitration done");
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd("read page", OFS_RPAGE, 16'h0001);
        rd("sp reg", OFS_SP, 16'h1000);
        $display("test second reset done");
        finish_test;
    end
endmodule
